// ==== pkg/oag_pkg.sv ====
// Purpose: Shared constants, types and helpers of the operand address generator
// Assumes: 8-bit register file, 16-bit program and data address spaces
// Notes:   Pointer reset values are plain defaults
package oag_pkg;

  // ----------------------------------------------------------------
  // Register-file locations and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OAG_WORKING_POINTER_ZERO_ADDR = 8'h_d6;
  localparam logic [7:0] OAG_WORKING_POINTER_ONE_ADDR = 8'h_d7;
  localparam logic [7:0] OAG_REGISTER_PAGE_SELECT_ADDR = 8'h_df;
  localparam logic [7:0] OAG_WORKING_POINTER_ZERO_RST = 8'h_c0;
  localparam logic [7:0] OAG_WORKING_POINTER_ONE_RST = 8'h_c8;
  localparam logic [7:0] OAG_REGISTER_PAGE_SELECT_RST = 8'h_00;
  // Lowest set-1 location that indexed mode cannot reach
  localparam logic [7:0] OAG_SET1_GUARD_LO = 8'h_c0;
  // Mask that keeps the 8-byte window base of a working pointer
  localparam logic [7:0] OAG_WINDOW_MASK = 8'h_f8;
  localparam logic [7:0] OAG_ZERO_PAGE = 8'h_00;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OAG_MODE_WORKING, OAG_MODE_INDEXED_REG, OAG_MODE_INDEXED_SHORT,
    OAG_MODE_INDEXED_LONG, OAG_MODE_DIRECT, OAG_MODE_INDIRECT,
    OAG_MODE_RELATIVE, OAG_MODE_IMM_BYTE, OAG_MODE_IMM_WORD
  } oag_mode_t;

  typedef enum logic [3:0] {
    OAG_INS_LOAD, OAG_INS_PMEM_LOAD, OAG_INS_XDATA_LOAD, OAG_INS_JUMP,
    OAG_INS_CALL, OAG_INS_BIT_FALSE, OAG_INS_BIT_TRUE, OAG_INS_DEC_BRANCH,
    OAG_INS_CMP_INC_EQ, OAG_INS_CMP_INC_NE, OAG_INS_REL_JUMP, OAG_INS_OTHER
  } oag_instr_t;

  typedef enum logic [1:0] {
    OAG_SPACE_REG, OAG_SPACE_PROG, OAG_SPACE_XDATA
  } oag_space_t;

  typedef enum logic [0:0] {
    OAG_ST_IDLE, OAG_ST_FETCH
  } oag_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    oag_mode_t mode;
    oag_instr_t instr;
    logic [7:0] field8;   // Base, short offset, pointer, displacement, byte
    logic [15:0] word16;  // Long offset, direct address, word immediate
    logic [3:0] wreg;     // Working register number
    logic set1;           // Register-file access targets set 1
  } oag_req_t;

  typedef struct packed {
    logic valid;
    logic refused;
    logic pc_load;
    oag_space_t space;
    logic [15:0] addr;
    logic [15:0] value;
  } oag_res_t;

  typedef struct packed {
    oag_state_t st;
    logic ready;
    oag_req_t req;
    logic need2;
    logic cnt;
    logic [15:0] pair;
    logic fetch_req;
    oag_space_t fetch_space;
    logic [15:0] fetch_addr;
    oag_res_t res;
  } oag_core_t;

  typedef struct packed {
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [7:0] page;
    logic [7:0] rd_data;
    logic rd_hit;
  } oag_ptr_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] oag_sext8(input logic [7:0] v);
    oag_sext8 = {{8{v[7]}}, v};
  endfunction

  function automatic logic [7:0] oag_wreg_addr(input logic [7:0] p0,
                                               input logic [7:0] p1,
                                               input logic [3:0] idx);
    oag_wreg_addr = ((idx[3] ? p1 : p0) & OAG_WINDOW_MASK) | {5'b0_0000, idx[2:0]};
  endfunction

endpackage

// ==== verilog/oag_ptr_regs.sv ====
// Purpose: Working pointers and page select held as register-file locations
// Assumes: Core register-file port, one write and one read per cycle
// Notes:   Read data is registered and valid one cycle after the address
`timescale 1ns/10ps

module oag_ptr_regs (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_hit,
  output logic [7:0] ptr0,
  output logic [7:0] ptr1,
  output logic [7:0] page
);

  oag_pkg::oag_ptr_t q, d;

  // Write decode and registered read-back
  always_comb begin
    d = q;
    if (wr_en && wr_addr == oag_pkg::OAG_WORKING_POINTER_ZERO_ADDR) begin
      d.ptr0 = wr_data;
    end else if (wr_en && wr_addr == oag_pkg::OAG_WORKING_POINTER_ONE_ADDR) begin
      d.ptr1 = wr_data;
    end else if (wr_en && wr_addr == oag_pkg::OAG_REGISTER_PAGE_SELECT_ADDR) begin
      d.page = wr_data;
    end
    d.rd_hit = 1'b1;
    if (rd_addr == oag_pkg::OAG_WORKING_POINTER_ZERO_ADDR) begin
      d.rd_data = q.ptr0;
    end else if (rd_addr == oag_pkg::OAG_WORKING_POINTER_ONE_ADDR) begin
      d.rd_data = q.ptr1;
    end else if (rd_addr == oag_pkg::OAG_REGISTER_PAGE_SELECT_ADDR) begin
      d.rd_data = q.page;
    end else begin
      d.rd_data = 8'h_00; // Other locations belong to the register file
      d.rd_hit = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{ptr0: oag_pkg::OAG_WORKING_POINTER_ZERO_RST,
             ptr1: oag_pkg::OAG_WORKING_POINTER_ONE_RST,
             page: oag_pkg::OAG_REGISTER_PAGE_SELECT_RST,
             rd_data: 8'h_00, rd_hit: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;
  assign rd_hit = q.rd_hit;
  assign ptr0 = q.ptr0;
  assign ptr1 = q.ptr1;
  assign page = q.page;

endmodule // oag_ptr_regs

// ==== verilog/oag_core.sv ====
// Purpose: Effective operand address generation for the 8-bit core
// Assumes: Operand fetch port answers with fetch_ack, data valid with ack
// Notes:   One request in flight; req_ready low during operand fetches until the result pulse
`timescale 1ns/10ps

module oag_core (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire oag_pkg::oag_req_t req,
  input wire logic [15:0] pc,
  output logic req_ready,
  output oag_pkg::oag_res_t res,
  output logic fetch_req,
  output oag_pkg::oag_space_t fetch_space,
  output logic [15:0] fetch_addr,
  input wire logic fetch_ack,
  input wire logic [7:0] fetch_data,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_addr,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_hit,
  output logic [7:0] register_page_select
);

  oag_pkg::oag_core_t q, d;
  logic [7:0] working_pointer_zero;
  logic [7:0] working_pointer_one;

  // ----------------------------------------------------------------
  // Pointer registers
  // ----------------------------------------------------------------
  oag_ptr_regs u_ptr (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wr_en(reg_wr_en),
    .wr_addr(reg_wr_addr),
    .wr_data(reg_wr_data),
    .rd_addr(reg_rd_addr),
    .rd_data(reg_rd_data),
    .rd_hit(reg_rd_hit),
    .ptr0(working_pointer_zero),
    .ptr1(working_pointer_one),
    .page(register_page_select)
  );

  // ----------------------------------------------------------------
  // Mode legality per instruction
  // ----------------------------------------------------------------
  function automatic logic mode_legal(input oag_pkg::oag_mode_t m,
                                      input oag_pkg::oag_instr_t i);
    logic mem_load;
    mem_load = (i == oag_pkg::OAG_INS_PMEM_LOAD) || (i == oag_pkg::OAG_INS_XDATA_LOAD);
    case (m)
      oag_pkg::OAG_MODE_INDEXED_REG: mode_legal = (i == oag_pkg::OAG_INS_LOAD);
      oag_pkg::OAG_MODE_INDEXED_SHORT: mode_legal = mem_load;
      oag_pkg::OAG_MODE_INDEXED_LONG: mode_legal = mem_load;
      oag_pkg::OAG_MODE_DIRECT: mode_legal = mem_load || (i == oag_pkg::OAG_INS_JUMP)
                                             || (i == oag_pkg::OAG_INS_CALL);
      oag_pkg::OAG_MODE_INDIRECT: mode_legal = (i == oag_pkg::OAG_INS_CALL);
      oag_pkg::OAG_MODE_RELATIVE: mode_legal = (i == oag_pkg::OAG_INS_BIT_FALSE)
        || (i == oag_pkg::OAG_INS_BIT_TRUE) || (i == oag_pkg::OAG_INS_DEC_BRANCH)
        || (i == oag_pkg::OAG_INS_CMP_INC_EQ) || (i == oag_pkg::OAG_INS_CMP_INC_NE)
        || (i == oag_pkg::OAG_INS_REL_JUMP);
      default: mode_legal = 1'b1;
    endcase
  endfunction

  // Memory space of a load, program space for everything else
  function automatic oag_pkg::oag_space_t load_space(input oag_pkg::oag_instr_t i);
    load_space = (i == oag_pkg::OAG_INS_XDATA_LOAD) ? oag_pkg::OAG_SPACE_XDATA
                                                    : oag_pkg::OAG_SPACE_PROG;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] sum8;
    logic [15:0] pair;
    sum8 = 8'h_00;
    pair = 16'h_0000;
    d = q;
    d.res.valid = 1'b0;
    d.res.refused = 1'b0;
    case (q.st)
      oag_pkg::OAG_ST_IDLE: begin
        if (req_valid && q.ready) begin
          d.req = req;
          d.res.valid = 1'b1;
          d.res.pc_load = 1'b0;
          d.res.space = oag_pkg::OAG_SPACE_REG;
          d.res.addr = 16'h_0000;
          d.res.value = 16'h_0000;
          d.cnt = 1'b0;
          d.need2 = 1'b1;
          if (!mode_legal(req.mode, req.instr)) begin
            d.res.refused = 1'b1;
          end else begin
            case (req.mode)
              oag_pkg::OAG_MODE_WORKING: begin
                d.res.addr = {oag_pkg::OAG_ZERO_PAGE,
                  oag_pkg::oag_wreg_addr(working_pointer_zero, working_pointer_one, req.wreg)};
              end
              oag_pkg::OAG_MODE_INDEXED_REG: begin
                d.res.valid = 1'b0;
                d.ready = 1'b0;
                d.need2 = 1'b0;
                d.st = oag_pkg::OAG_ST_FETCH;
                d.fetch_req = 1'b1;
                d.fetch_space = oag_pkg::OAG_SPACE_REG;
                d.fetch_addr = {oag_pkg::OAG_ZERO_PAGE,
                  oag_pkg::oag_wreg_addr(working_pointer_zero, working_pointer_one, req.wreg)};
              end
              oag_pkg::OAG_MODE_INDEXED_SHORT, oag_pkg::OAG_MODE_INDEXED_LONG: begin
                // Fetch base pair, high byte first
                d.res.valid = 1'b0;
                d.ready = 1'b0;
                d.st = oag_pkg::OAG_ST_FETCH;
                d.fetch_req = 1'b1;
                d.fetch_space = oag_pkg::OAG_SPACE_REG;
                d.fetch_addr = {oag_pkg::OAG_ZERO_PAGE, oag_pkg::oag_wreg_addr(
                  working_pointer_zero, working_pointer_one, {req.wreg[3:1], 1'b0})};
              end
              oag_pkg::OAG_MODE_INDIRECT: begin
                d.res.valid = 1'b0;
                d.ready = 1'b0;
                d.st = oag_pkg::OAG_ST_FETCH;
                d.fetch_req = 1'b1;
                d.fetch_space = oag_pkg::OAG_SPACE_PROG;
                d.fetch_addr = {oag_pkg::OAG_ZERO_PAGE, req.field8};
              end
              oag_pkg::OAG_MODE_DIRECT: begin
                d.res.addr = req.word16;
                d.res.space = load_space(req.instr);
                d.res.pc_load = (req.instr == oag_pkg::OAG_INS_JUMP)
                                || (req.instr == oag_pkg::OAG_INS_CALL);
              end
              oag_pkg::OAG_MODE_RELATIVE: begin
                d.res.addr = pc + oag_pkg::oag_sext8(req.field8);
                d.res.space = oag_pkg::OAG_SPACE_PROG;
                d.res.pc_load = 1'b1;
              end
              oag_pkg::OAG_MODE_IMM_BYTE: begin
                d.res.value = {8'h_00, req.field8};
              end
              default: begin
                d.res.value = req.word16;
              end
            endcase
          end
        end
      end
      default: begin
        if (fetch_ack) begin
          d.fetch_req = 1'b0;
          if (q.need2 && !q.cnt) begin
            // Second byte sits next door; pointer fetches stay in their page
            d.pair[15:8] = fetch_data;
            d.cnt = 1'b1;
            d.fetch_req = 1'b1;
            d.fetch_addr = {q.fetch_addr[15:8], q.fetch_addr[7:0] + 8'h_01};
          end else begin
            pair = {q.pair[15:8], fetch_data};
            d.pair = pair;
            d.st = oag_pkg::OAG_ST_IDLE;
            d.ready = 1'b1;
            d.res.valid = 1'b1;
            d.res.space = load_space(q.req.instr);
            case (q.req.mode)
              oag_pkg::OAG_MODE_INDEXED_REG: begin
                sum8 = q.req.field8 + fetch_data;
                d.res.space = oag_pkg::OAG_SPACE_REG;
                d.res.addr = {oag_pkg::OAG_ZERO_PAGE, sum8};
                d.res.refused = q.req.set1 && (sum8 >= oag_pkg::OAG_SET1_GUARD_LO);
              end
              oag_pkg::OAG_MODE_INDEXED_SHORT: begin
                d.res.addr = pair + oag_pkg::oag_sext8(q.req.field8);
              end
              oag_pkg::OAG_MODE_INDEXED_LONG: begin
                // Long offset wraps in 16 bits
                d.res.addr = pair + q.req.word16;
              end
              default: begin
                // Fetched pair is the call target
                d.res.addr = pair;
                d.res.space = oag_pkg::OAG_SPACE_PROG;
                d.res.pc_load = 1'b1;
              end
            endcase
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign req_ready = q.ready;
  assign res = q.res;
  assign fetch_req = q.fetch_req;
  assign fetch_space = q.fetch_space;
  assign fetch_addr = q.fetch_addr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_SET1_GUARD: assert property (
    res.valid && !res.refused && q.req.mode == oag_pkg::OAG_MODE_INDEXED_REG
    && q.req.set1 |-> res.addr[7:0] < oag_pkg::OAG_SET1_GUARD_LO)
    else $error("Set-1 upper area reached by indexed mode");
  AST_SHORT_SEXT: assert property (
    res.valid && !res.refused && q.req.mode == oag_pkg::OAG_MODE_INDEXED_SHORT
    |-> res.addr == q.pair + {{8{q.req.field8[7]}}, q.req.field8})
    else $error("Short offset not sign-extended");
  AST_IDX_REG_SUM: assert property (
    res.valid && !res.refused && q.req.mode == oag_pkg::OAG_MODE_INDEXED_REG
    |-> res.addr == {8'h_00, 8'(q.req.field8 + q.pair[7:0])})
    else $error("Indexed register sum wrong");
  AST_IDX_LONG_SUM: assert property (
    res.valid && !res.refused && q.req.mode == oag_pkg::OAG_MODE_INDEXED_LONG
    |-> res.addr == 16'(q.pair + q.req.word16))
    else $error("Indexed long sum wrong");
  AST_DIRECT_ADDR: assert property (
    req_valid && req_ready && req.mode == oag_pkg::OAG_MODE_DIRECT
    && req.instr == oag_pkg::OAG_INS_CALL |=> res.valid && res.pc_load
    && res.addr == $past(req.word16))
    else $error("Direct call target wrong");
  AST_INDIRECT_CALL_ONLY: assert property (
    req_valid && req_ready && req.mode == oag_pkg::OAG_MODE_INDIRECT
    && req.instr != oag_pkg::OAG_INS_CALL |=> res.valid && res.refused)
    else $error("Indirect mode accepted for non-call");
  AST_INDIRECT_ZERO_PAGE: assert property (
    fetch_req && q.req.mode == oag_pkg::OAG_MODE_INDIRECT
    |-> fetch_addr[15:8] == 8'h_00 && fetch_space == oag_pkg::OAG_SPACE_PROG)
    else $error("Indirect pointer outside lowest page");
  AST_REL_TARGET: assert property (
    req_valid && req_ready && req.mode == oag_pkg::OAG_MODE_RELATIVE
    && req.instr == oag_pkg::OAG_INS_REL_JUMP |=> res.valid && res.pc_load
    && res.addr == 16'($past(pc) + {{8{$past(req.field8[7])}}, $past(req.field8)}))
    else $error("Relative target wrong");
  AST_IMM_BYTE: assert property (
    req_valid && req_ready && req.mode == oag_pkg::OAG_MODE_IMM_BYTE
    |=> res.valid && res.value == {8'h_00, $past(req.field8)})
    else $error("Byte immediate wrong");

endmodule // oag_core

// ==== sim/oag_mem_model.sv ====
// Purpose: Memory and register-file model answering operand byte fetches
// Assumes: One fetch in flight, request held until acknowledged
// Notes:   Byte at an address is its low byte XOR a5; lat adds wait cycles
`timescale 1ns/10ps

module oag_mem_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic [3:0] lat,
  output logic fetch_ack,
  output logic [7:0] fetch_data
);
  logic [3:0] wait_q;

  // Ack after lat idle cycles; data flips outside the ack so stale bytes never match
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 4'h0;
      fetch_ack <= 1'b0;
      fetch_data <= 8'h_00;
    end else if (fetch_req && !fetch_ack && wait_q >= lat) begin
      wait_q <= 4'h0;
      fetch_ack <= 1'b1;
      fetch_data <= fetch_addr[7:0] ^ 8'h_a5;
    end else begin
      fetch_ack <= 1'b0;
      fetch_data <= ~fetch_data;
      if (fetch_req && !fetch_ack) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule // oag_mem_model

// ==== sim/operand_address_generator_tb.sv ====
// Purpose: Self-checking bench for the operand address generator core
// Assumes: Model byte = address low byte XOR a5, pointers reset to c0/c8
// Notes:   Row fields m/i hold the mode and instruction enum codes
`timescale 1ns/10ps

module operand_address_generator_tb;
  typedef struct packed {
    logic [3:0] m;
    logic [3:0] i;
    logic [7:0] f8;
    logic [15:0] w16;
    logic [3:0] wr;
    logic s1;
    logic [15:0] pc;
    logic rf;
    logic pl;
    logic [1:0] sp;
    logic [15:0] ad;
  } oag_row_t;

  // Space code 3 means the space is not checked; value rows are modes 7 and 8
  localparam oag_row_t rows [27] = '{
    '{4'h6,4'ha,8'h_80,16'h_0000,4'h0,1'b0,16'h_1000,1'b0,1'b1,2'h3,16'h_0f80},
    '{4'h6,4'h5,8'h_7f,16'h_0000,4'h0,1'b0,16'h_fff0,1'b0,1'b1,2'h3,16'h_006f},
    '{4'h6,4'h6,8'h_01,16'h_0000,4'h0,1'b0,16'h_1000,1'b0,1'b1,2'h3,16'h_1001},
    '{4'h6,4'h7,8'h_fe,16'h_0000,4'h0,1'b0,16'h_1000,1'b0,1'b1,2'h3,16'h_0ffe},
    '{4'h6,4'h8,8'h_10,16'h_0000,4'h0,1'b0,16'h_1000,1'b0,1'b1,2'h3,16'h_1010},
    '{4'h6,4'h9,8'h_f0,16'h_0000,4'h0,1'b0,16'h_1000,1'b0,1'b1,2'h3,16'h_0ff0},
    '{4'h6,4'h0,8'h_10,16'h_0000,4'h0,1'b0,16'h_1000,1'b1,1'b0,2'h3,16'h_0000},
    '{4'h4,4'h3,8'h_00,16'h_abcd,4'h0,1'b0,16'h_1000,1'b0,1'b1,2'h1,16'h_abcd},
    '{4'h4,4'h4,8'h_00,16'h_1234,4'h0,1'b0,16'h_1000,1'b0,1'b1,2'h1,16'h_1234},
    '{4'h4,4'h1,8'h_00,16'h_5678,4'h0,1'b0,16'h_1000,1'b0,1'b0,2'h3,16'h_5678},
    '{4'h4,4'h2,8'h_00,16'h_9abc,4'h0,1'b0,16'h_1000,1'b0,1'b0,2'h3,16'h_9abc},
    '{4'h5,4'h4,8'h_40,16'h_0000,4'h0,1'b0,16'h_1000,1'b0,1'b1,2'h3,16'h_e5e4},
    '{4'h5,4'h4,8'h_ff,16'h_0000,4'h0,1'b0,16'h_1000,1'b0,1'b1,2'h3,16'h_5aa5},
    '{4'h5,4'h3,8'h_40,16'h_0000,4'h0,1'b0,16'h_1000,1'b1,1'b0,2'h3,16'h_0000},
    '{4'h7,4'hb,8'h_3c,16'h_0000,4'h0,1'b0,16'h_1000,1'b0,1'b0,2'h3,16'h_003c},
    '{4'h8,4'h0,8'h_00,16'h_beef,4'h0,1'b0,16'h_1000,1'b0,1'b0,2'h3,16'h_beef},
    '{4'h1,4'h0,8'h_20,16'h_0000,4'h3,1'b0,16'h_1000,1'b0,1'b0,2'h0,16'h_0086},
    '{4'h1,4'h0,8'h_f0,16'h_0000,4'h3,1'b0,16'h_1000,1'b0,1'b0,2'h0,16'h_0056},
    '{4'h1,4'h0,8'h_5a,16'h_0000,4'h3,1'b1,16'h_1000,1'b1,1'b0,2'h0,16'h_00c0},
    '{4'h1,4'h0,8'h_59,16'h_0000,4'h3,1'b1,16'h_1000,1'b0,1'b0,2'h0,16'h_00bf},
    '{4'h1,4'h1,8'h_20,16'h_0000,4'h3,1'b0,16'h_1000,1'b1,1'b0,2'h3,16'h_0000},
    '{4'h3,4'h1,8'h_00,16'h_f000,4'h9,1'b0,16'h_1000,1'b0,1'b0,2'h1,16'h_5d6c},
    '{4'h3,4'h2,8'h_00,16'h_0010,4'h2,1'b0,16'h_1000,1'b0,1'b0,2'h2,16'h_6776},
    '{4'h2,4'h2,8'h_80,16'h_0000,4'h2,1'b0,16'h_1000,1'b0,1'b0,2'h2,16'h_66e6},
    '{4'h3,4'h0,8'h_00,16'h_0010,4'h2,1'b0,16'h_1000,1'b1,1'b0,2'h3,16'h_0000},
    '{4'h4,4'hb,8'h_00,16'h_1234,4'h0,1'b0,16'h_1000,1'b1,1'b0,2'h3,16'h_0000},
    '{4'h0,4'hb,8'h_00,16'h_0000,4'ha,1'b0,16'h_1000,1'b0,1'b0,2'h0,16'h_00ca}
  };

  logic ref_clk, resetn, req_valid, req_ready, fetch_req, fetch_ack;
  logic reg_wr_en, reg_rd_hit;
  logic [3:0] lat;
  logic [7:0] fetch_data, reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data, page;
  logic [15:0] pc, fetch_addr;
  oag_pkg::oag_req_t req;
  oag_pkg::oag_res_t res;
  int n_fail, samples_checked;
  oag_pkg::oag_space_t fetch_space;
  logic [3:0] cur_m;

  oag_core dut_u (.ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid), .req(req),
    .pc(pc), .req_ready(req_ready), .res(res), .fetch_req(fetch_req),
    .fetch_space(fetch_space),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit),
    .register_page_select(page));

  oag_mem_model mem_u (.ref_clk(ref_clk), .resetn(resetn), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .lat(lat), .fetch_ack(fetch_ack), .fetch_data(fetch_data));

  // 50 MHz clock
  always begin
    #10;
    ref_clk = ~ref_clk;
  end

  // Operand fetches stay in the lowest page; only indirect calls read program memory
  always @(negedge ref_clk) begin
    if (resetn === 1'b1 && fetch_req === 1'b1) begin
      chk(fetch_addr[15:8], 16'h_0000);
      chk(fetch_space, (cur_m == 4'h5) ? 16'h_0001 : 16'h_0000);
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("TB: %0d compares, %0d mismatches", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until taken; waits are bounded so a hang ends the run
  task automatic run_row(input oag_row_t r);
    int k;
    @(negedge ref_clk);
    cur_m = r.m;
    req = '{oag_pkg::oag_mode_t'(r.m), oag_pkg::oag_instr_t'(r.i), r.f8, r.w16, r.wr, r.s1};
    pc = r.pc;
    req_valid = 1'b1;
    k = 0;
    while (req_ready !== 1'b1 && k < 50) begin
      @(negedge ref_clk);
      k++;
    end
    @(posedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'b0;
    while (res.valid !== 1'b1 && k < 50) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 50) begin
      n_fail++;
      summarize();
    end else begin
      chk(res.refused, r.rf);
      chk(res.pc_load, r.pl);
      if (r.sp != 2'h3) chk(res.space, r.sp);
      if (r.m >= 4'h7) chk(res.value, r.ad);
      else if (!(r.rf && r.sp == 2'h3)) chk(res.addr, r.ad);
      $display("TB: row mode %h instr %h done", r.m, r.i);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
    @(negedge ref_clk);
    reg_rd_addr = a;
    @(posedge ref_clk);
    #1;
    chk(reg_rd_data, d);
    chk(reg_rd_hit, h);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_wr_addr = a;
    reg_wr_data = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    pc = 16'h_0000;
    lat = 4'h0;
    cur_m = 4'h0;
    reg_wr_en = 1'b0;
    reg_wr_addr = 8'h_00;
    reg_wr_data = 8'h_00;
    reg_rd_addr = 8'h_00;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    foreach (rows[n]) run_row(rows[n]);
    // Slow partner on a long indexed load
    lat = 4'h3;
    run_row(rows[21]);
    // Moved pointer window selects a new working register
    wr(8'h_d6, 8'h_37);
    rd(8'h_d6, 8'h_37, 1'b1);
    run_row('{4'h0,4'hb,8'h_00,16'h_0000,4'h2,1'b0,16'h_1000,1'b0,1'b0,2'h0,16'h_0032});
    wr(8'h_df, 8'h_5a);
    chk(page, 8'h_5a);
    // Mid-run reset restores idle and pointer defaults
    @(negedge ref_clk);
    resetn = 1'b0;
    @(negedge ref_clk);
    chk(req_ready, 1'b1);
    chk(res.valid, 1'b0);
    chk(fetch_req, 1'b0);
    chk(page, 8'h_00);
    resetn = 1'b1;
    rd(8'h_d6, 8'h_c0, 1'b1);
    rd(8'h_d7, 8'h_c8, 1'b1);
    rd(8'h_df, 8'h_00, 1'b1);
    rd(8'h_d5, 8'h_00, 1'b0);
    $display("TB: reset and register tests done");
    summarize();
  end
endmodule // operand_address_generator_tb
